// ==== verilog/disc_tag_control_sector_port.sv ====
// Drive-side decoder for the control-select and current-sector tags.
//
// Local design decisions: the address map and the AXI4-Lite register port.
`default_nettype none

module disc_tag_control_sector_port #(
  parameter int OFFSET_HOLD_CYC = disc_tag_pkg::OFFSET_HOLD_CYC
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  // Controller side
  input wire logic TAG_CTRL_I,
  input wire logic TAG_SECTOR_I,
  input wire logic [9:0] BUS_OUT_I,
  output logic [7:0] BUS_IN_O,
  // Drive side
  input wire logic [7:0] STATUS_WORD_I,
  input wire logic [7:0] SECTOR_ADDR_I,
  input wire logic FAULT_COND_I,
  input wire logic SEEK_ERR_I,
  input wire logic ON_CYL_I,
  input wire logic CHAN_RESERVE_I,
  input wire logic CHAN_PRIORITY_I,
  output logic WRITE_EN_O,
  output logic READ_EN_O,
  output logic READ_SYNC_O,
  output logic OFFSET_PLUS_O,
  output logic OFFSET_MINUS_O,
  output logic ON_CYL_O,
  output logic FAULT_O,
  output logic SEEK_ERR_O,
  output logic ADDR_MARK_WRITE_O,
  output logic ADDR_MARK_SEARCH_O,
  output logic RETURN_TO_ZERO_O,
  output logic ADDR_CLEAR_O,
  output logic STROBE_EARLY_O,
  output logic STROBE_LATE_O,
  output logic CHAN_RELEASE_O,
  output logic CHAN_RESERVED_O,
  output logic CHAN_PRIORITY_O,
  // AXI4-Lite slave
  input wire logic [11:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [11:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I
);
  //////////////////////////////////////////////////////////////////////////
  // Tag decode
  logic [disc_tag_pkg::CFG_W-1:0] cfg_q;
  logic ext_addr;
  logic dual_chan;
  logic ctrl_take;
  logic sector_take;
  logic blocked;
  logic wr_en_d;
  logic rd_en_d;
  logic am_bit;
  logic am_rd_d;
  logic am_rd_q;
  logic off_plus_d;
  logic off_minus_d;
  logic offset_start;
  logic fault_q;
  logic fault_d;
  logic seek_err_q;
  logic seek_err_d;
  logic res_d;
  logic pri_d;
  logic [7:0] bus_in_d;
  logic [disc_tag_pkg::PULSE_N-1:0] req;
  logic [disc_tag_pkg::PULSE_N-1:0] fire;
  logic [disc_tag_pkg::PULSE_N-1:0] fired_q;
  logic clear_ok;
  logic rtz_fire;
  logic release_fire;

  assign ext_addr = cfg_q[disc_tag_pkg::CFG_EXT_ADDR_BIT];
  assign dual_chan = cfg_q[disc_tag_pkg::CFG_DUAL_CHAN_BIT];
  // Sector tag wins the bus-out lines so their undefined contents never act
  assign ctrl_take = TAG_CTRL_I & ~TAG_SECTOR_I;
  assign sector_take = TAG_SECTOR_I & ~TAG_CTRL_I & ~ext_addr;
  assign blocked = fault_q | seek_err_q;
  assign wr_en_d = ctrl_take & BUS_OUT_I[disc_tag_pkg::WRITE_GATE_BIT]
                   & ~blocked;
  assign rd_en_d = ctrl_take & BUS_OUT_I[disc_tag_pkg::READ_GATE_BIT]
                   & ~blocked;
  assign am_bit = ctrl_take & BUS_OUT_I[disc_tag_pkg::ADDR_MARK_BIT];
  assign am_rd_d = rd_en_d & am_bit;
  assign off_plus_d = ctrl_take & BUS_OUT_I[disc_tag_pkg::OFFSET_PLUS_BIT];
  assign off_minus_d = ctrl_take & BUS_OUT_I[disc_tag_pkg::OFFSET_MINUS_BIT];
  // Either offset newly applied restarts the on-cylinder hold-off
  assign offset_start = (off_plus_d & ~OFFSET_PLUS_O)
                        | (off_minus_d & ~OFFSET_MINUS_O);

  // Once per tag assertion: a bit held high must not repeat its action
  genvar g;
  generate
    for (g = 0; g < disc_tag_pkg::PULSE_N; g++) begin : g_pulse
      assign req[g] = ctrl_take & BUS_OUT_I[disc_tag_pkg::PULSE_BIT[g]];
      assign fire[g] = req[g] & ~fired_q[g];
      always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) fired_q[g] <= 1'b0;
        else fired_q[g] <= ctrl_take & (fired_q[g] | req[g]);
      end
    end
  endgenerate

  assign rtz_fire = fire[disc_tag_pkg::PULSE_RETURN_TO_ZERO];
  assign release_fire = fire[disc_tag_pkg::PULSE_RELEASE] & dual_chan;
  // A live fault keeps the latch set even against a clear
  assign clear_ok = fire[disc_tag_pkg::PULSE_FAULT_CLEAR] & ~FAULT_COND_I;
  assign fault_d = FAULT_COND_I | (fault_q & ~clear_ok);
  assign seek_err_d = SEEK_ERR_I | (seek_err_q & ~rtz_fire);
  assign res_d = CHAN_RESERVE_I | (CHAN_RESERVED_O & ~release_fire);
  assign pri_d = CHAN_PRIORITY_I | (CHAN_PRIORITY_O & ~release_fire);
  assign bus_in_d = ctrl_take ? STATUS_WORD_I :
                    sector_take ? SECTOR_ADDR_I : 8'h00;

  offset_hold_if hold ();
  assign hold.start = offset_start;

  offset_hold_timer #(.HOLD_CYC(OFFSET_HOLD_CYC)) u_hold (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .hold(hold)
  );

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      WRITE_EN_O <= 1'b0;
      READ_EN_O <= 1'b0;
      READ_SYNC_O <= 1'b0;
      am_rd_q <= 1'b0;
      ADDR_MARK_WRITE_O <= 1'b0;
      ADDR_MARK_SEARCH_O <= 1'b0;
      OFFSET_PLUS_O <= 1'b0;
      OFFSET_MINUS_O <= 1'b0;
      ON_CYL_O <= 1'b0;
      STROBE_EARLY_O <= 1'b0;
      STROBE_LATE_O <= 1'b0;
      BUS_IN_O <= 8'h00;
    end else begin
      WRITE_EN_O <= wr_en_d;
      READ_EN_O <= rd_en_d;
      READ_SYNC_O <= rd_en_d & ~READ_EN_O;
      am_rd_q <= am_rd_d;
      ADDR_MARK_WRITE_O <= wr_en_d & am_bit;
      ADDR_MARK_SEARCH_O <= am_rd_d & ~am_rd_q;
      OFFSET_PLUS_O <= off_plus_d;
      OFFSET_MINUS_O <= off_minus_d;
      ON_CYL_O <= ON_CYL_I & ~hold.busy & ~offset_start;
      STROBE_EARLY_O <= ctrl_take
        & BUS_OUT_I[disc_tag_pkg::STROBE_EARLY_BIT];
      STROBE_LATE_O <= ctrl_take
        & BUS_OUT_I[disc_tag_pkg::STROBE_LATE_BIT];
      BUS_IN_O <= bus_in_d;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      fault_q <= 1'b0;
      seek_err_q <= 1'b0;
      RETURN_TO_ZERO_O <= 1'b0;
      ADDR_CLEAR_O <= 1'b0;
      CHAN_RELEASE_O <= 1'b0;
      CHAN_RESERVED_O <= 1'b0;
      CHAN_PRIORITY_O <= 1'b0;
    end else begin
      fault_q <= fault_d;
      seek_err_q <= seek_err_d;
      RETURN_TO_ZERO_O <= rtz_fire;
      ADDR_CLEAR_O <= rtz_fire;
      CHAN_RELEASE_O <= release_fire;
      CHAN_RESERVED_O <= res_d;
      CHAN_PRIORITY_O <= pri_d;
    end
  end

  assign FAULT_O = fault_q;
  assign SEEK_ERR_O = seek_err_q;

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite register slave; one write and one read in flight at most
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic wr_cfg_hit;
  logic ar_take;
  logic [31:0] status_word;
  logic [31:0] rdata_d;
  logic rd_hit;

  assign do_write = ~AWREADY_O & ~WREADY_O & ~BVALID_O;
  assign wr_cfg_hit = (awaddr_q == disc_tag_pkg::CONFIG_OFFSET);
  assign ar_take = ARVALID_I & ARREADY_O;
  assign status_word = {16'h0000, SECTOR_ADDR_I, CHAN_PRIORITY_O,
                        CHAN_RESERVED_O, hold.busy, READ_EN_O, WRITE_EN_O,
                        ON_CYL_O, seek_err_q, fault_q};
  assign rd_hit = (ARADDR_I == disc_tag_pkg::CONFIG_OFFSET)
                  | (ARADDR_I == disc_tag_pkg::STATUS_OFFSET);
  assign rdata_d = (ARADDR_I == disc_tag_pkg::CONFIG_OFFSET) ?
                   {{(32-disc_tag_pkg::CFG_W){1'b0}}, cfg_q} :
                   (ARADDR_I == disc_tag_pkg::STATUS_OFFSET) ?
                   status_word : 32'h00000000;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      AWREADY_O <= 1'b1;
      WREADY_O <= 1'b1;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (AWVALID_I & AWREADY_O) begin
        AWREADY_O <= 1'b0;
        awaddr_q <= AWADDR_I;
      end else if (BVALID_O & BREADY_I) AWREADY_O <= 1'b1;
      if (WVALID_I & WREADY_O) begin
        WREADY_O <= 1'b0;
        wdata_q <= WDATA_I;
        wstrb_q <= WSTRB_I;
      end else if (BVALID_O & BREADY_I) WREADY_O <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      BVALID_O <= 1'b0;
      BRESP_O <= disc_tag_pkg::RESP_OKAY;
      cfg_q <= disc_tag_pkg::CONFIG_RESET;
    end else if (do_write) begin
      BVALID_O <= 1'b1;
      BRESP_O <= wr_cfg_hit | (awaddr_q == disc_tag_pkg::STATUS_OFFSET) ?
                 disc_tag_pkg::RESP_OKAY : disc_tag_pkg::RESP_SLVERR;
      if (wr_cfg_hit & wstrb_q[0]) cfg_q <= wdata_q[disc_tag_pkg::CFG_W-1:0];
    end else if (BVALID_O & BREADY_I) BVALID_O <= 1'b0;
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ARREADY_O <= 1'b1;
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h00000000;
      RRESP_O <= disc_tag_pkg::RESP_OKAY;
    end else if (ar_take) begin
      ARREADY_O <= 1'b0;
      RVALID_O <= 1'b1;
      RDATA_O <= rdata_d;
      RRESP_O <= rd_hit ? disc_tag_pkg::RESP_OKAY : disc_tag_pkg::RESP_SLVERR;
    end else if (RVALID_O & RREADY_I) begin
      RVALID_O <= 1'b0;
      ARREADY_O <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_rtz_cmd;
    ctrl_take && BUS_OUT_I[disc_tag_pkg::RETURN_TO_ZERO_BIT]
    && !fired_q[disc_tag_pkg::PULSE_RETURN_TO_ZERO];
  endsequence

  sequence s_rtz_done;
    RETURN_TO_ZERO_O && ADDR_CLEAR_O ##1 !RETURN_TO_ZERO_O;
  endsequence

  sequence s_offset_cmd;
    ctrl_take && BUS_OUT_I[disc_tag_pkg::OFFSET_PLUS_BIT] && !OFFSET_PLUS_O;
  endsequence

  chk_write_gate_refuse: assert property (@(posedge CLK_I) disable iff (RST_I)
    blocked |=> !WRITE_EN_O)
    else $error("write gate accepted during fault or seek error");

  chk_read_gate_refuse: assert property (@(posedge CLK_I) disable iff (RST_I)
    blocked |=> !READ_EN_O)
    else $error("read gate accepted during fault or seek error");

  chk_read_sync_edge: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(READ_EN_O) |-> READ_SYNC_O ##1 !READ_SYNC_O)
    else $error("read sync did not pulse on read gate edge");

  chk_offset_plus: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_offset_cmd |=> OFFSET_PLUS_O)
    else $error("offset plus not applied");

  // The offset may be dropped early; only the on-cylinder mask must stay
  chk_offset_on_cyl: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_offset_cmd |=> !ON_CYL_O [*8])
    else $error("on-cylinder not masked after offset");

  chk_offset_minus: assert property (@(posedge CLK_I) disable iff (RST_I)
    ctrl_take && BUS_OUT_I[disc_tag_pkg::OFFSET_MINUS_BIT] && !OFFSET_MINUS_O
    |=> OFFSET_MINUS_O && !ON_CYL_O)
    else $error("offset minus not applied");

  chk_fault_clear: assert property (@(posedge CLK_I) disable iff (RST_I)
    fault_q && fire[disc_tag_pkg::PULSE_FAULT_CLEAR]
    |=> fault_q == $past(FAULT_COND_I))
    else $error("fault latch mishandled on clear");

  chk_mark_write: assert property (@(posedge CLK_I) disable iff (RST_I)
    ADDR_MARK_WRITE_O |-> WRITE_EN_O)
    else $error("address mark written without write gate");

  chk_mark_search: assert property (@(posedge CLK_I) disable iff (RST_I)
    ADDR_MARK_SEARCH_O |-> READ_EN_O && $past(!am_rd_q))
    else $error("address mark search without fresh read gate");

  chk_rtz_actions: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_rtz_cmd |=> s_rtz_done)
    else $error("return to zero not a single clean pulse");

  chk_seek_err_reset: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_rtz_cmd and !SEEK_ERR_I |=> !seek_err_q)
    else $error("seek error survived return to zero");

  chk_strobe_shift: assert property (@(posedge CLK_I) disable iff (RST_I)
    ctrl_take |=>
    STROBE_EARLY_O == $past(BUS_OUT_I[disc_tag_pkg::STROBE_EARLY_BIT])
    && STROBE_LATE_O == $past(BUS_OUT_I[disc_tag_pkg::STROBE_LATE_BIT]))
    else $error("data strobe shift not following bus-out");

  chk_release_dual: assert property (@(posedge CLK_I) disable iff (RST_I)
    CHAN_RELEASE_O |-> $past(dual_chan)
    && CHAN_RESERVED_O == $past(CHAN_RESERVE_I)
    && CHAN_PRIORITY_O == $past(CHAN_PRIORITY_I))
    else $error("release acted wrongly");

  chk_status_out: assert property (@(posedge CLK_I) disable iff (RST_I)
    ctrl_take |=> BUS_IN_O == $past(STATUS_WORD_I))
    else $error("status word not returned on bus-in");

  chk_sector_out: assert property (@(posedge CLK_I) disable iff (RST_I)
    TAG_SECTOR_I && !TAG_CTRL_I |=> BUS_IN_O ==
    ($past(ext_addr) ? 8'h00 : $past(SECTOR_ADDR_I)))
    else $error("sector address not returned on bus-in");

  chk_sector_ignore: assert property (@(posedge CLK_I) disable iff (RST_I)
    TAG_SECTOR_I |=> !WRITE_EN_O && !READ_EN_O && !RETURN_TO_ZERO_O)
    else $error("bus-out acted on during sector tag");
endmodule : disc_tag_control_sector_port

`default_nettype wire

// ==== verilog/disc_tag_pkg.sv ====
// Constants shared by the control-select and current-sector tag port.
//
// Overview of operation
// - Control tag latches bus-out into control logic
// - Write gate refused on seek error/fault
// - Read gate refused on seek error/fault
// - Accepted read gate edge starts preamble sync
// - Offset plus shifts positioner toward spindle
// - Offset minus shifts positioner away from spindle
// - Any offset forces on-cylinder low 2.75 ms
// - Fault clear pulse clears latch if fault gone
// - Address-mark enable with write writes mark
// - Address-mark enable with read starts search
// - Return-to-zero pulse moves positioner to zero
// - Return-to-zero clears head, cylinder, seek error
// - Bit 7 strobes read data early
// - Bit 8 strobes read data late
// - Bit 9 clears channel status, dual units
// - Control tag returns normal status on bus-in
// - Sector tag returns sector address on bus-in
// - Sector tag ignores all ten bus-out lines
// - Sector tag unavailable with extended addressing
`default_nettype none

package disc_tag_pkg;
  localparam int BUS_OUT_W = 10;
  localparam int BUS_IN_W = 8;

  // Bus-out bit assignment during the control-select tag
  localparam int WRITE_GATE_BIT = 0;
  localparam int READ_GATE_BIT = 1;
  localparam int OFFSET_PLUS_BIT = 2;
  localparam int OFFSET_MINUS_BIT = 3;
  localparam int FAULT_CLEAR_BIT = 4;
  localparam int ADDR_MARK_BIT = 5;
  localparam int RETURN_TO_ZERO_BIT = 6;
  localparam int STROBE_EARLY_BIT = 7;
  localparam int STROBE_LATE_BIT = 8;
  localparam int CHANNEL_RELEASE_BIT = 9;

  // One-shot actions, index into the pulse generator
  localparam int PULSE_N = 3;
  localparam int PULSE_FAULT_CLEAR = 0;
  localparam int PULSE_RETURN_TO_ZERO = 1;
  localparam int PULSE_RELEASE = 2;
  localparam int PULSE_BIT [PULSE_N] = '{FAULT_CLEAR_BIT, RETURN_TO_ZERO_BIT,
                                         CHANNEL_RELEASE_BIT};

  // Register map
  localparam int AXI_AW = 12;
  localparam logic [AXI_AW-1:0] CONFIG_OFFSET = 12'h000;
  localparam logic [AXI_AW-1:0] STATUS_OFFSET = 12'h004;
  localparam logic [1:0] CONFIG_RESET = 2'h0;
  localparam int CFG_EXT_ADDR_BIT = 0;
  localparam int CFG_DUAL_CHAN_BIT = 1;
  localparam int CFG_W = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // On-cylinder hold-off after an offset command
  localparam real OFFSET_HOLD_MS = 2.75;
  localparam real CLK_PERIOD_NS = 4.0;
  localparam int OFFSET_HOLD_CYC =
    int'($ceil(OFFSET_HOLD_MS * 1.0E6 / CLK_PERIOD_NS));
  localparam int HOLD_CNT_W = 20;
endpackage : disc_tag_pkg

`default_nettype wire

// ==== verilog/offset_hold_if.sv ====
// Carrier between the tag decoder and the on-cylinder hold-off timer.
`default_nettype none

interface offset_hold_if;
  logic start;
  logic busy;
  modport ctl (output start, input busy);
  modport tmr (input start, output busy);
endinterface : offset_hold_if

`default_nettype wire

// ==== verilog/offset_hold_timer.sv ====
// Hold-off timer that masks on-cylinder after an offset command.
`default_nettype none

module offset_hold_timer #(
  parameter int HOLD_CYC = disc_tag_pkg::OFFSET_HOLD_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  offset_hold_if.tmr hold
);
  logic [disc_tag_pkg::HOLD_CNT_W-1:0] cnt_q;
  logic [disc_tag_pkg::HOLD_CNT_W-1:0] cnt_d;

  // A fresh offset restarts the full hold-off
  assign cnt_d = hold.start ? disc_tag_pkg::HOLD_CNT_W'(HOLD_CYC) :
                 (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
  assign hold.busy = (cnt_q != '0);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) cnt_q <= '0;
    else cnt_q <= cnt_d;
  end

  chk_hold_ends_late: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(hold.busy) |-> $past(cnt_q) == 1 && !$past(hold.start))
    else $error("hold-off ended before its count ran out");
endmodule : offset_hold_timer

`default_nettype wire

// ==== bench/ctrl.sv ====
// Behavioural model of the disc controller driving tags and bus-out.
`default_nettype none

module ctrl (
  input wire logic clk_i,
  output logic tag_ctrl_o,
  output logic tag_sector_o,
  output logic [9:0] bus_out_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    tag_ctrl_o = 1'b0;
    tag_sector_o = 1'b0;
    bus_out_o = 10'h155;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control tag holds the command word until the next call
  task automatic cmd(input logic [9:0] b);
    @(posedge clk_i);
    tag_ctrl_o <= 1'b1;
    tag_sector_o <= 1'b0;
    bus_out_o <= b;
  endtask : cmd

  // Bus-out is undefined under the sector tag; all ones is the worst case
  task automatic sector();
    @(posedge clk_i);
    tag_ctrl_o <= 1'b0;
    tag_sector_o <= 1'b1;
    bus_out_o <= 10'h3FF;
  endtask : sector

  // Dropping the tag ends a pulse; stale bits are inverted, never kept
  task automatic idle();
    @(posedge clk_i);
    tag_ctrl_o <= 1'b0;
    tag_sector_o <= 1'b0;
    bus_out_o <= ~bus_out_o;
  endtask : idle
endmodule : ctrl

`default_nettype wire

// ==== bench/disc_tag_control_sector_port_tb.sv ====
// Self-checking bench for the control-select and current-sector tag port.
`default_nettype none

module disc_tag_control_sector_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Short hold-off keeps the run brief
  localparam int HOLD = 20;
  localparam logic [1:0] OK = disc_tag_pkg::RESP_OKAY;
  localparam logic [1:0] ER = disc_tag_pkg::RESP_SLVERR;
  localparam logic [11:0] CFG = disc_tag_pkg::CONFIG_OFFSET;
  localparam logic [11:0] STA = disc_tag_pkg::STATUS_OFFSET;
  logic CLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic TAG_CTRL_I, TAG_SECTOR_I;
  logic [9:0] BUS_OUT_I;
  logic [7:0] BUS_IN_O, STATUS_WORD_I, SECTOR_ADDR_I;
  logic FAULT_COND_I, SEEK_ERR_I, ON_CYL_I, CHAN_RESERVE_I, CHAN_PRIORITY_I;
  logic WRITE_EN_O, READ_EN_O, READ_SYNC_O, OFFSET_PLUS_O, OFFSET_MINUS_O;
  logic ON_CYL_O, FAULT_O, SEEK_ERR_O, ADDR_MARK_WRITE_O, ADDR_MARK_SEARCH_O;
  logic RETURN_TO_ZERO_O, ADDR_CLEAR_O, STROBE_EARLY_O, STROBE_LATE_O;
  logic CHAN_RELEASE_O, CHAN_RESERVED_O, CHAN_PRIORITY_O;
  logic [11:0] AWADDR_I, ARADDR_I;
  logic [31:0] WDATA_I, RDATA_O, rd;
  logic [3:0] WSTRB_I;
  logic AWVALID_I, AWREADY_O, WVALID_I, WREADY_O, BVALID_O, BREADY_I;
  logic ARVALID_I, ARREADY_O, RVALID_O, RREADY_I;
  logic [1:0] BRESP_O, RRESP_O, rs;
  int mismatches = 0;
  int checks_done = 0;

  always #2 CLK_I = ~CLK_I;

  disc_tag_control_sector_port #(.OFFSET_HOLD_CYC(HOLD))
    disc_tag_control_sector_port_inst (
    .CLK_I(CLK_I), .RST_I(RST_I), .TAG_CTRL_I(TAG_CTRL_I),
    .TAG_SECTOR_I(TAG_SECTOR_I), .BUS_OUT_I(BUS_OUT_I), .BUS_IN_O(BUS_IN_O),
    .STATUS_WORD_I(STATUS_WORD_I), .SECTOR_ADDR_I(SECTOR_ADDR_I),
    .FAULT_COND_I(FAULT_COND_I), .SEEK_ERR_I(SEEK_ERR_I),
    .ON_CYL_I(ON_CYL_I), .CHAN_RESERVE_I(CHAN_RESERVE_I),
    .CHAN_PRIORITY_I(CHAN_PRIORITY_I), .WRITE_EN_O(WRITE_EN_O),
    .READ_EN_O(READ_EN_O), .READ_SYNC_O(READ_SYNC_O),
    .OFFSET_PLUS_O(OFFSET_PLUS_O), .OFFSET_MINUS_O(OFFSET_MINUS_O),
    .ON_CYL_O(ON_CYL_O), .FAULT_O(FAULT_O), .SEEK_ERR_O(SEEK_ERR_O),
    .ADDR_MARK_WRITE_O(ADDR_MARK_WRITE_O),
    .ADDR_MARK_SEARCH_O(ADDR_MARK_SEARCH_O),
    .RETURN_TO_ZERO_O(RETURN_TO_ZERO_O), .ADDR_CLEAR_O(ADDR_CLEAR_O),
    .STROBE_EARLY_O(STROBE_EARLY_O), .STROBE_LATE_O(STROBE_LATE_O),
    .CHAN_RELEASE_O(CHAN_RELEASE_O), .CHAN_RESERVED_O(CHAN_RESERVED_O),
    .CHAN_PRIORITY_O(CHAN_PRIORITY_O), .AWADDR_I(AWADDR_I),
    .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WDATA_I(WDATA_I),
    .WSTRB_I(WSTRB_I), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
    .BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
    .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O),
    .RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .RVALID_O(RVALID_O),
    .RREADY_I(RREADY_I));

  ctrl ctrl_inst (.clk_i(CLK_I), .tag_ctrl_o(TAG_CTRL_I),
    .tag_sector_o(TAG_SECTOR_I), .bus_out_o(BUS_OUT_I));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Outputs settle between edges, so look at the falling edge
  task automatic smp(input int n);
    repeat (n) @(negedge CLK_I);
  endtask : smp

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  task automatic hang();
    mismatches++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    stop_test();
  endtask : hang

  ////////////////////////////////////////////////////////////////////////////
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge CLK_I);
    AWADDR_I <= a;
    WDATA_I <= d;
    AWVALID_I <= 1'b1;
    WVALID_I <= 1'b1;
    BREADY_I <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge CLK_I);
      if (AWREADY_O) AWVALID_I <= 1'b0;
      if (WREADY_O) WVALID_I <= 1'b0;
      if (BVALID_O) break;
    end
    if (i == 64) hang();
    rs = BRESP_O;
    BREADY_I <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a);
    int i;
    @(posedge CLK_I);
    ARADDR_I <= a;
    ARVALID_I <= 1'b1;
    RREADY_I <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge CLK_I);
      if (ARREADY_O) ARVALID_I <= 1'b0;
      if (RVALID_O) break;
    end
    if (i == 64) hang();
    rd = RDATA_O;
    rs = RRESP_O;
    RREADY_I <= 1'b0;
  endtask : axi_rd

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    axi_rd(CFG);
    chk({rs, rd}, {OK, 32'h0});
    axi_wr(CFG, 32'h3);
    axi_rd(CFG);
    chk({rs, rd}, {OK, 32'h3});
    // A write without the low byte lane must leave the config alone
    @(posedge CLK_I);
    WSTRB_I <= WSTRB_I << 1;
    axi_wr(CFG, 32'h0);
    chk(rs, OK);
    axi_rd(CFG);
    chk({rs, rd}, {OK, 32'h3});
    @(posedge CLK_I);
    WSTRB_I <= WSTRB_I | 4'h1;
    axi_wr(STA, 32'hFFFF_FFFF);
    chk(rs, OK);
    axi_rd(STA);
    chk({rs, rd}, {OK, 16'h0, SECTOR_ADDR_I, 8'h04});
    axi_wr(12'h008, 32'h1);
    chk(rs, ER);
    axi_rd(12'h008);
    chk({rs, rd}, {ER, 32'h0});
    axi_wr(CFG, 32'h0);
    $display("t_regs done");
  endtask : t_regs

  // Write then read back to back under one tag assertion
  task automatic t_gates();
    ctrl_inst.cmd(10'h0A1);
    smp(2);
    chk({WRITE_EN_O, READ_EN_O, ADDR_MARK_WRITE_O, STROBE_EARLY_O,
      STROBE_LATE_O, BUS_IN_O}, {5'h16, 8'hA5});
    @(posedge CLK_I);
    STATUS_WORD_I <= ~STATUS_WORD_I;
    ctrl_inst.cmd(10'h122);
    smp(2);
    chk({WRITE_EN_O, READ_EN_O, READ_SYNC_O, ADDR_MARK_SEARCH_O,
      STROBE_LATE_O, STROBE_EARLY_O, BUS_IN_O},
      {6'h1E, 8'h5A});
    smp(1);
    chk({READ_EN_O, READ_SYNC_O, ADDR_MARK_SEARCH_O}, 3'h4);
    ctrl_inst.idle();
    smp(2);
    chk({WRITE_EN_O, READ_EN_O, BUS_IN_O}, 10'h0);
    $display("t_gates done");
  endtask : t_gates

  task automatic t_fault();
    @(posedge CLK_I);
    FAULT_COND_I <= 1'b1;
    ctrl_inst.cmd(10'h013);
    smp(2);
    chk({FAULT_O, WRITE_EN_O, READ_EN_O}, 3'h4);
    @(posedge CLK_I);
    FAULT_COND_I <= 1'b0;
    ctrl_inst.idle();
    ctrl_inst.cmd(10'h010);
    smp(2);
    chk(FAULT_O, 1'b0);
    ctrl_inst.cmd(10'h001);
    smp(2);
    chk(WRITE_EN_O, 1'b1);
    ctrl_inst.idle();
    $display("t_fault done");
  endtask : t_fault

  // Write gate rides with the return so the latch clear shows on it one cycle later
  task automatic t_rtz();
    @(posedge CLK_I);
    SEEK_ERR_I <= 1'b1;
    @(posedge CLK_I);
    SEEK_ERR_I <= 1'b0;
    smp(1);
    chk(SEEK_ERR_O, 1'b1);
    ctrl_inst.cmd(10'h041);
    smp(2);
    chk({RETURN_TO_ZERO_O, ADDR_CLEAR_O, SEEK_ERR_O, WRITE_EN_O},
      4'hC);
    smp(1);
    chk({RETURN_TO_ZERO_O, ADDR_CLEAR_O, SEEK_ERR_O, WRITE_EN_O},
      4'h1);
    ctrl_inst.idle();
    $display("t_rtz done");
  endtask : t_rtz

  task automatic t_offset();
    logic m;
    for (int k = 0; k < 2; k++) begin
      m = k[0];
      ctrl_inst.cmd(10'h004 << k);
      smp(2);
      chk({OFFSET_PLUS_O, OFFSET_MINUS_O, ON_CYL_O},
        {~m, m, 1'b0});
      ctrl_inst.idle();
      smp(16);
      chk(ON_CYL_O, 1'b0);
      smp(8);
      chk({OFFSET_PLUS_O, OFFSET_MINUS_O, ON_CYL_O}, 3'h1);
    end
    // Raw on-cylinder still passes through outside a hold-off
    @(posedge CLK_I);
    ON_CYL_I <= ~ON_CYL_I;
    smp(2);
    chk(ON_CYL_O, 1'b0);
    @(posedge CLK_I);
    ON_CYL_I <= ~ON_CYL_I;
    $display("t_offset done");
  endtask : t_offset

  task automatic t_sector();
    ctrl_inst.sector();
    smp(2);
    chk({BUS_IN_O, WRITE_EN_O, READ_EN_O, RETURN_TO_ZERO_O, OFFSET_PLUS_O,
      STROBE_EARLY_O, ON_CYL_O}, {8'hFF, 6'h1});
    @(posedge CLK_I);
    SECTOR_ADDR_I <= 8'h5A;
    smp(2);
    chk(BUS_IN_O, 8'h5A);
    ctrl_inst.idle();
    axi_wr(CFG, 32'h1);
    ctrl_inst.sector();
    smp(2);
    chk(BUS_IN_O, 8'h00);
    ctrl_inst.idle();
    axi_wr(CFG, 32'h0);
    $display("t_sector done");
  endtask : t_sector

  // Release is refused on a single-channel unit, then honoured once
  task automatic t_release();
    @(posedge CLK_I);
    CHAN_RESERVE_I <= 1'b1;
    CHAN_PRIORITY_I <= 1'b1;
    @(posedge CLK_I);
    CHAN_RESERVE_I <= 1'b0;
    CHAN_PRIORITY_I <= 1'b0;
    ctrl_inst.cmd(10'h200);
    smp(2);
    chk({CHAN_RELEASE_O, CHAN_RESERVED_O, CHAN_PRIORITY_O}, 3'h3);
    ctrl_inst.idle();
    axi_wr(CFG, 32'h2);
    ctrl_inst.cmd(10'h200);
    smp(2);
    chk({CHAN_RELEASE_O, CHAN_RESERVED_O, CHAN_PRIORITY_O}, 3'h4);
    smp(1);
    chk(CHAN_RELEASE_O, 1'b0);
    ctrl_inst.idle();
    axi_wr(CFG, 32'h0);
    $display("t_release done");
  endtask : t_release

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    STATUS_WORD_I = 8'hA5;
    SECTOR_ADDR_I = 8'hFF;
    FAULT_COND_I = 1'b0;
    SEEK_ERR_I = 1'b0;
    ON_CYL_I = 1'b1;
    CHAN_RESERVE_I = 1'b0;
    CHAN_PRIORITY_I = 1'b0;
    AWADDR_I = 12'h000;
    ARADDR_I = 12'h000;
    WDATA_I = 32'h0;
    WSTRB_I = 4'hF;
    AWVALID_I = 1'b0;
    WVALID_I = 1'b0;
    BREADY_I = 1'b0;
    ARVALID_I = 1'b0;
    RREADY_I = 1'b0;
    repeat (16) @(posedge CLK_I);
    RST_I <= 1'b0;
    t_regs();
    t_gates();
    t_fault();
    t_rtz();
    t_offset();
    t_sector();
    t_release();
    stop_test();
  end

  initial begin
    repeat (50000) @(posedge CLK_I);
    hang();
  end
endmodule : disc_tag_control_sector_port_tb

`default_nettype wire
